// >>> bench/regmap_props.sv
module regmap_props #(
    parameter int NVM_WRITE_CYCLES = 20,
    parameter logic [7:0] FAMILY_CODE = 8'h5a
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic req,
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic done,
    input wire logic [7:0] rdata,
    input wire logic stretch,
    input wire logic PUMP_ON
);
    timeunit 1ns;
    timeprecision 1ns;
    logic store_wr;
    // the indirect value register programs the store as well
    assign store_wr = req && we && (addr[7] || addr == 8'h12);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    done_after_req_a: assert property (req |=> done)
        else $error("request not answered");
    no_stray_done_a: assert property (!req |=> !done)
        else $error("answer without request");
    rdata_quiet_a: assert property (!done |-> rdata == 8'h00)
        else $error("read data outside answer");
    family_read_a: assert property (req && !we && addr == 8'h00
        |=> rdata == FAMILY_CODE)
        else $error("family code wrong");
    pump_start_a: assert property (store_wr |=> PUMP_ON)
        else $error("pump not on for store write");
    pump_span_a: assert property (store_wr
        |-> ##NVM_WRITE_CYCLES PUMP_ON ##1 !PUMP_ON)
        else $error("program time wrong");
    pump_cause_a: assert property ($rose(PUMP_ON)
        |-> $past(store_wr))
        else $error("pump on without store write");
    lower_no_pump_a: assert property (req && we && !addr[7]
        && addr != 8'h12 && !PUMP_ON |=> !PUMP_ON)
        else $error("pump on for control page write");
    stretch_prog_a: assert property (stretch |-> PUMP_ON)
        else $error("clock held while store idle");
    clock_held_a: assert property (stretch |-> !req)
        else $error("request while clock held");
    cover property (store_wr ##1 stretch);
    cover property (req && !we && addr[7]);
    cover property ($fell(PUMP_ON) && !stretch);
endmodule

// >>> bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = 20;
    // identification values are arbitrary
    localparam logic [7:0] FAM = 8'h3c;
    localparam logic [7:0] REV = 8'h07;
    logic CLOCK, RSTN, CMD_WR, CMD_RD, ACQ_ACTIVE, PUMP_ON, saw_stretch;
    logic [3:0] CMD_ADDR;
    logic [7:0] CMD_WDATA, CMD_RDATA, v;
    logic [15:0] STRAP, TEMPERATURE;
    logic [31:0] MARKER_LABELS;
    logic [7:0] rw [14] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h22, 8'h24,
        8'h25, 8'h27, 8'h28, 8'h2a, 8'h2b, 8'h2d, 8'h3a, 8'h3c};
    logic [7:0] rsv [7] = '{8'h23, 8'h26, 8'h29, 8'h2c, 8'h3b, 8'h05,
        8'h70};
    int mismatches, check_count, busy_n;
    regmap_link_if link();
    regmap_device #(.NVM_WRITE_CYCLES(N), .FAMILY_CODE(FAM),
        .REVISION_CODE(REV)) u_regmap_device (.CLOCK(CLOCK), .RSTN(RSTN),
        .LINK(link), .STRAP(STRAP), .TEMPERATURE(TEMPERATURE),
        .PUMP_ON(PUMP_ON), .MARKER_LABELS(MARKER_LABELS));
    regmap_host #(.NVM_WRITE_CYCLES(N), .WRITE_LIMIT(4)) u_regmap_host (
        .CLOCK(CLOCK), .RSTN(RSTN), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD),
        .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA),
        .ACQ_ACTIVE(ACQ_ACTIVE), .LINK(link));
    regmap_props #(.NVM_WRITE_CYCLES(N), .FAMILY_CODE(FAM)) u_regmap_props (
        .CLOCK(CLOCK), .RSTN(RSTN), .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .done(link.done),
        .rdata(link.rdata), .stretch(link.stretch), .PUMP_ON(PUMP_ON));
    initial begin
        CLOCK = 1'b0;
        forever #10 CLOCK = ~CLOCK;
    end
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    // strobes drop at the taking edge; the next task waits one more edge
    task automatic hwr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        CMD_WR <= 1'b1;
        CMD_ADDR <= a;
        CMD_WDATA <= d;
        @(posedge CLOCK);
        CMD_WR <= 1'b0;
    endtask
    task automatic hrd(input logic [3:0] a, output logic [7:0] d);
        @(posedge CLOCK);
        CMD_RD <= 1'b1;
        CMD_ADDR <= a;
        @(posedge CLOCK);
        CMD_RD <= 1'b0;
        #1 d = CMD_RDATA;
    endtask
    task automatic wait_idle;
        logic [7:0] s;
        busy_n = 0;
        saw_stretch = 1'b0;
        for (int i = 0; i < 100; i++) begin
            hrd(regmap_pkg::H_STATUS_ADDR, s);
            saw_stretch |= link.stretch;
            if (s[regmap_pkg::ST_BUSY_BIT] === 1'b0) break;
            busy_n++;
        end
        chk("idle", 1'b0, s[regmap_pkg::ST_BUSY_BIT]);
    endtask
    task automatic link_wr(input logic [7:0] a, input logic [7:0] d);
        hwr(regmap_pkg::H_TADDR_ADDR, a);
        hwr(regmap_pkg::H_TDATA_ADDR, d);
        hwr(regmap_pkg::H_GO_ADDR, 8'h01);
        wait_idle();
    endtask
    task automatic link_rd(input logic [7:0] a, output logic [7:0] d);
        hwr(regmap_pkg::H_TADDR_ADDR, a);
        hwr(regmap_pkg::H_GO_ADDR, 8'h02);
        wait_idle();
        hrd(regmap_pkg::H_RDATA_ADDR, d);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge CLOCK);
        mismatches++;
        conclude();
    end
    initial begin
        {RSTN, CMD_WR, CMD_RD, ACQ_ACTIVE} = 4'h0;
        CMD_ADDR = 4'h0;
        CMD_WDATA = 8'h00;
        STRAP = 16'hbeef;
        TEMPERATURE = 16'h1234;
        repeat (16) @(posedge CLOCK);
        RSTN <= 1'b1;
        link_rd(8'h13, v); chk("mask reset", 8'hff, v);
        link_rd(8'h7e, v); chk("link ctrl", 8'h01, v);
        link_wr(8'h00, 8'hff);
        link_wr(8'h20, 8'h00);
        link_rd(8'h00, v); chk("family", FAM, v);
        link_rd(8'h01, v); chk("revision", REV, v);
        link_rd(8'h20, v); chk("strap high", 8'hbe, v);
        link_rd(8'h21, v); chk("strap low", 8'hef, v);
        link_rd(8'h60, v); chk("temp high", 8'h12, v);
        link_rd(8'h61, v); chk("temp low", 8'h34, v);
        foreach (rw[i]) link_wr(rw[i], 8'(i + 64));
        foreach (rw[i]) begin
            link_rd(rw[i], v);
            chk("rw reg", 8'(i + 64), v);
        end
        chk("labels", 32'h40414243, MARKER_LABELS);
        foreach (rsv[i]) begin
            link_wr(rsv[i], 8'hff);
            link_rd(rsv[i], v);
            chk("reserved", 8'h00, v);
        end
        link_wr(8'h85, 8'haa);
        chk("stretch", 1'b1, saw_stretch);
        link_rd(8'h85, v); chk("upper", 8'haa, v);
        link_wr(8'hff, 8'h5c);
        link_rd(8'hff, v); chk("top", 8'h5c, v);
        ACQ_ACTIVE <= 1'b1;
        link_wr(8'h87, 8'h11);
        hrd(regmap_pkg::H_STATUS_ADDR, v);
        chk("acq refusal", 1'b1, v[regmap_pkg::ST_ACQ_BIT]);
        hwr(regmap_pkg::H_STATUS_ADDR, 8'h06);
        ACQ_ACTIVE <= 1'b0;
        hrd(regmap_pkg::H_COUNT_ADDR, v); chk("count", 8'h02, v);
        link_wr(8'h11, 8'h85);
        link_rd(8'h12, v); chk("indirect", 8'haa, v);
        link_wr(8'h13, 8'h0f);
        link_wr(8'h12, 8'h55);
        chk("store hold", 1'b1, busy_n >= N / 2);
        link_wr(8'h11, 8'h85);
        link_rd(8'h12, v); chk("masked", 8'ha5, v);
        link_rd(8'h85, v); chk("page kept", 8'haa, v);
        link_wr(8'h7e, 8'h00);
        hwr(regmap_pkg::H_CTRL_ADDR, 8'h01);
        link_wr(8'h86, 8'h33);
        chk("no stretch", 1'b0, saw_stretch);
        chk("timer wait", 1'b1, busy_n >= N / 2);
        link_rd(8'h86, v); chk("timer byte", 8'h33, v);
        link_wr(8'h88, 8'h77);
        hrd(regmap_pkg::H_STATUS_ADDR, v);
        chk("limit", 1'b1, v[regmap_pkg::ST_LIMIT_BIT]);
        @(posedge CLOCK) RSTN <= 1'b0;
        repeat (4) @(posedge CLOCK);
        RSTN <= 1'b1;
        link_rd(8'h1c, v); chk("label reset", 8'h00, v);
        conclude();
    end
endmodule

// >>> verilog/pin_sync3.sv
module pin_sync3 #(
    parameter int WIDTH = 16
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] value,
    output logic agree
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q;
    logic [2:0] fill_q;
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            fill_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            fill_q <= {fill_q[1:0], 1'b1};
        end
    end
    assign value = s3_q;
    // stages reset to equal zeros; trust a match only once pin data
    // has reached the last stage, else a capture follows every reset
    assign agree = fill_q[2] && (s2_q == s3_q);
endmodule

// >>> verilog/regmap_device.sv
// Strobed register access is this design's own decision.
module regmap_device #(
    parameter int NVM_WRITE_CYCLES = regmap_pkg::NVM_WRITE_CYCLES,
    // identification values are arbitrary
    parameter logic [7:0] FAMILY_CODE = 8'h5a,
    parameter logic [7:0] REVISION_CODE = 8'h01
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    regmap_link_if.dev LINK,
    input wire logic [15:0] STRAP,
    input wire logic [15:0] TEMPERATURE,
    output logic PUMP_ON,
    output logic [31:0] MARKER_LABELS
);
    localparam int CW = $clog2(NVM_WRITE_CYCLES + 1);

    logic [7:0] upper_q [0:127];
    logic [7:0] nvm_q [0:127];
    logic [7:0] vec_q [0:regmap_pkg::VECTOR_BYTES-1];
    logic [7:0] vec_d [0:regmap_pkg::VECTOR_BYTES-1];
    logic [7:0] ind_addr_q, ind_addr_d, ind_value_q, ind_value_d;
    logic [7:0] ind_mask_q, ind_mask_d, link_ctrl_q, link_ctrl_d;
    logic [7:0] mark_q [0:3];
    logic [7:0] mark_d [0:3];
    logic [15:0] pin_q, pin_d, temp_q, temp_d;
    logic captured_q, captured_d;
    logic prog_q, prog_d, stretch_q, stretch_d, done_q, done_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [6:0] pend_addr_q, pend_addr_d;
    logic [7:0] pend_data_q, pend_data_d, rdata_q, rdata_d, rd_mux;
    logic wr, upper_wr, nvm_start, commit;
    logic [6:0] start_addr;
    logic [7:0] start_data, nvm_old;
    logic [15:0] strap_sync;
    logic strap_agree;
    int vidx;

    pin_sync3 #(.WIDTH(16)) strap_sync_i (
        .CLOCK(CLOCK),
        .RSTN(RSTN),
        .pins(STRAP),
        .value(strap_sync),
        .agree(strap_agree)
    );

    // maps a vector address to its byte slot, -1 for middle bytes
    function automatic int vector_slot(input logic [7:0] a);
        case (a)
            regmap_pkg::PH0_HIGH_ADDR: vector_slot = 0;
            regmap_pkg::PH0_LOW_ADDR: vector_slot = 1;
            regmap_pkg::PH1_HIGH_ADDR: vector_slot = 2;
            regmap_pkg::PH1_LOW_ADDR: vector_slot = 3;
            regmap_pkg::PH2_HIGH_ADDR: vector_slot = 4;
            regmap_pkg::PH2_LOW_ADDR: vector_slot = 5;
            regmap_pkg::PH3_HIGH_ADDR: vector_slot = 6;
            regmap_pkg::PH3_LOW_ADDR: vector_slot = 7;
            regmap_pkg::GRAY_HIGH_ADDR: vector_slot = 8;
            regmap_pkg::GRAY_LOW_ADDR: vector_slot = 9;
            default: vector_slot = -1;
        endcase
    endfunction

    assign wr = LINK.req && LINK.we;
    assign upper_wr = wr && LINK.addr[7];
    assign commit = prog_q && (cnt_q == '0);
    assign nvm_old = nvm_q[ind_addr_q[6:0]];
    assign vidx = vector_slot(LINK.addr);

    // register write decode
    always_comb begin
        ind_addr_d = ind_addr_q;
        ind_value_d = ind_value_q;
        ind_mask_d = ind_mask_q;
        link_ctrl_d = link_ctrl_q;
        mark_d = mark_q;
        vec_d = vec_q;
        nvm_start = 1'b0;
        start_addr = LINK.addr[6:0];
        start_data = LINK.wdata;
        if (upper_wr) begin
            nvm_start = 1'b1;
        end else if (wr) begin
            case (LINK.addr)
                regmap_pkg::IND_ADDR_ADDR: begin
                    ind_addr_d = LINK.wdata;
                    // indirect read: preload the stored byte
                    ind_value_d = nvm_q[LINK.wdata[6:0]];
                end
                regmap_pkg::IND_VALUE_ADDR: begin
                    ind_value_d = LINK.wdata;
                    nvm_start = 1'b1;
                    start_addr = ind_addr_q[6:0];
                    start_data = (nvm_old & ~ind_mask_q)
                               | (LINK.wdata & ind_mask_q);
                end
                regmap_pkg::IND_MASK_ADDR: ind_mask_d = LINK.wdata;
                regmap_pkg::MARK_FB_ADDR: mark_d[0] = LINK.wdata;
                regmap_pkg::MARK_FF_ADDR: mark_d[1] = LINK.wdata;
                regmap_pkg::MARK_LB_ADDR: mark_d[2] = LINK.wdata;
                regmap_pkg::MARK_LF_ADDR: mark_d[3] = LINK.wdata;
                regmap_pkg::LINK_CTRL_ADDR: link_ctrl_d = LINK.wdata;
                default: begin
                    if (vidx >= 0) begin
                        vec_d[vidx] = LINK.wdata;
                    end
                    // anything else is reserved or read-only
                end
            endcase
        end
    end

    // read decode over all 256 locations
    always_comb begin
        rd_mux = 8'h00;
        if (LINK.addr[7]) begin
            rd_mux = upper_q[LINK.addr[6:0]];
        end else begin
            case (LINK.addr)
                regmap_pkg::FAMILY_ADDR: rd_mux = FAMILY_CODE;
                regmap_pkg::REVISION_ADDR: rd_mux = REVISION_CODE;
                regmap_pkg::IND_ADDR_ADDR: rd_mux = ind_addr_q;
                regmap_pkg::IND_VALUE_ADDR: rd_mux = ind_value_q;
                regmap_pkg::IND_MASK_ADDR: rd_mux = ind_mask_q;
                regmap_pkg::MARK_FB_ADDR: rd_mux = mark_q[0];
                regmap_pkg::MARK_FF_ADDR: rd_mux = mark_q[1];
                regmap_pkg::MARK_LB_ADDR: rd_mux = mark_q[2];
                regmap_pkg::MARK_LF_ADDR: rd_mux = mark_q[3];
                regmap_pkg::PIN_HIGH_ADDR: rd_mux = pin_q[15:8];
                regmap_pkg::PIN_LOW_ADDR: rd_mux = pin_q[7:0];
                regmap_pkg::TEMP_HIGH_ADDR: rd_mux = temp_q[15:8];
                regmap_pkg::TEMP_LOW_ADDR: rd_mux = temp_q[7:0];
                regmap_pkg::LINK_CTRL_ADDR: rd_mux = link_ctrl_q;
                default: begin
                    if (vidx >= 0) begin
                        rd_mux = vec_q[vidx];
                    end
                end
            endcase
        end
    end

    // store programming, answer and capture
    always_comb begin
        prog_d = prog_q;
        cnt_d = cnt_q;
        pend_addr_d = pend_addr_q;
        pend_data_d = pend_data_q;
        if (nvm_start) begin
            // a new write restarts the full program time
            prog_d = 1'b1;
            cnt_d = CW'(NVM_WRITE_CYCLES - 1);
            pend_addr_d = start_addr;
            pend_data_d = start_data;
        end else if (commit) begin
            prog_d = 1'b0;
        end else if (prog_q) begin
            cnt_d = cnt_q - CW'(1);
        end
        stretch_d = prog_d && link_ctrl_d[regmap_pkg::STRETCH_BIT];
        done_d = LINK.req;
        rdata_d = (LINK.req && !LINK.we) ? rd_mux : 8'h00;
        captured_d = captured_q || strap_agree;
        pin_d = (!captured_q && strap_agree) ? strap_sync : pin_q;
        temp_d = TEMPERATURE;
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ind_addr_q <= regmap_pkg::REG_RESET;
            ind_value_q <= regmap_pkg::REG_RESET;
            ind_mask_q <= regmap_pkg::MASK_RESET;
            link_ctrl_q <= regmap_pkg::LINK_CTRL_RESET;
            mark_q <= '{default: regmap_pkg::REG_RESET};
            vec_q <= '{default: regmap_pkg::REG_RESET};
            pin_q <= '0;
            temp_q <= '0;
            captured_q <= 1'b0;
            prog_q <= 1'b0;
            cnt_q <= '0;
            pend_addr_q <= '0;
            pend_data_q <= regmap_pkg::REG_RESET;
            stretch_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= regmap_pkg::REG_RESET;
        end else begin
            ind_addr_q <= ind_addr_d;
            ind_value_q <= ind_value_d;
            ind_mask_q <= ind_mask_d;
            link_ctrl_q <= link_ctrl_d;
            mark_q <= mark_d;
            vec_q <= vec_d;
            pin_q <= pin_d;
            temp_q <= temp_d;
            captured_q <= captured_d;
            prog_q <= prog_d;
            cnt_q <= cnt_d;
            pend_addr_q <= pend_addr_d;
            pend_data_q <= pend_data_d;
            stretch_q <= stretch_d;
            done_q <= done_d;
            rdata_q <= rdata_d;
        end
    end

    // upper page reloads from the store on reset, as after power-on
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            upper_q <= nvm_q;
        end else if (upper_wr) begin
            upper_q[LINK.addr[6:0]] <= LINK.wdata;
        end
    end

    // the store has no reset: its content survives
    always_ff @(posedge CLOCK) begin
        if (commit) begin
            nvm_q[pend_addr_q] <= pend_data_q;
        end
    end

    assign LINK.done = done_q;
    assign LINK.rdata = rdata_q;
    assign LINK.stretch = stretch_q;
    assign PUMP_ON = prog_q;
    assign MARKER_LABELS = {mark_q[0], mark_q[1], mark_q[2], mark_q[3]};
endmodule

// >>> verilog/regmap_host.sv
module regmap_host #(
    parameter int NVM_WRITE_CYCLES = regmap_pkg::NVM_WRITE_CYCLES,
    parameter int WRITE_LIMIT = regmap_pkg::NVM_WRITE_LIMIT
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic CMD_WR,
    input wire logic CMD_RD,
    input wire logic [3:0] CMD_ADDR,
    input wire logic [7:0] CMD_WDATA,
    output logic [7:0] CMD_RDATA,
    input wire logic ACQ_ACTIVE,
    regmap_link_if.host LINK
);
    localparam int CW = $clog2(NVM_WRITE_CYCLES + 1);

    regmap_pkg::host_state_t state_q, state_d;
    logic [7:0] ctrl_q, ctrl_d, taddr_q, taddr_d, tdata_q, tdata_d;
    logic [7:0] rdata_q, rdata_d, count_q, count_d, cmd_rdata_q, cmd_rdata_d;
    logic acq_err_q, acq_err_d, lim_err_q, lim_err_d;
    logic req_q, req_d, we_q, we_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic go_wr, go_rd, nvm_target;

    assign go_wr = CMD_WR && (CMD_ADDR == regmap_pkg::H_GO_ADDR)
                 && CMD_WDATA[regmap_pkg::GO_WRITE_BIT];
    assign go_rd = CMD_WR && (CMD_ADDR == regmap_pkg::H_GO_ADDR)
                 && CMD_WDATA[regmap_pkg::GO_READ_BIT];
    // an indirect value write programs the store as well
    assign nvm_target = taddr_q[7]
                      || (taddr_q == regmap_pkg::IND_VALUE_ADDR);

    always_comb begin
        state_d = state_q;
        ctrl_d = ctrl_q;
        taddr_d = taddr_q;
        tdata_d = tdata_q;
        rdata_d = rdata_q;
        count_d = count_q;
        acq_err_d = acq_err_q;
        lim_err_d = lim_err_q;
        req_d = 1'b0;
        we_d = we_q;
        cnt_d = cnt_q;
        cmd_rdata_d = 8'h00;
        if (CMD_WR && state_q == regmap_pkg::H_IDLE) begin
            case (CMD_ADDR)
                regmap_pkg::H_CTRL_ADDR: ctrl_d = CMD_WDATA;
                regmap_pkg::H_TADDR_ADDR: taddr_d = CMD_WDATA;
                regmap_pkg::H_TDATA_ADDR: tdata_d = CMD_WDATA;
                default: ;
            endcase
        end
        // write-one-to-clear; a new error in the same cycle wins
        if (CMD_WR && CMD_ADDR == regmap_pkg::H_STATUS_ADDR) begin
            if (CMD_WDATA[regmap_pkg::ST_ACQ_BIT]) acq_err_d = 1'b0;
            if (CMD_WDATA[regmap_pkg::ST_LIMIT_BIT]) lim_err_d = 1'b0;
        end
        case (state_q)
            regmap_pkg::H_IDLE: begin
                if (go_wr) begin
                    if (nvm_target && ACQ_ACTIVE) begin
                        acq_err_d = 1'b1;
                    end else if (nvm_target
                                 && count_q >= 8'(WRITE_LIMIT)) begin
                        lim_err_d = 1'b1;
                    end else begin
                        req_d = 1'b1;
                        we_d = 1'b1;
                        state_d = regmap_pkg::H_WAIT_DONE;
                        if (nvm_target) begin
                            count_d = count_q + 8'h01;
                        end
                    end
                end else if (go_rd) begin
                    req_d = 1'b1;
                    we_d = 1'b0;
                    state_d = regmap_pkg::H_WAIT_DONE;
                end
            end
            regmap_pkg::H_WAIT_DONE: begin
                if (LINK.done) begin
                    if (!we_q) begin
                        rdata_d = LINK.rdata;
                        state_d = regmap_pkg::H_IDLE;
                    end else if (!nvm_target) begin
                        state_d = regmap_pkg::H_IDLE;
                    end else if (LINK.stretch) begin
                        state_d = regmap_pkg::H_WAIT_STRETCH;
                    end else if (ctrl_q[regmap_pkg::TIMER_MODE_BIT]) begin
                        cnt_d = CW'(NVM_WRITE_CYCLES - 1);
                        state_d = regmap_pkg::H_WAIT_TIMER;
                    end else begin
                        state_d = regmap_pkg::H_IDLE;
                    end
                end
            end
            regmap_pkg::H_WAIT_STRETCH: begin
                if (!LINK.stretch) state_d = regmap_pkg::H_IDLE;
            end
            regmap_pkg::H_WAIT_TIMER: begin
                if (cnt_q == '0) begin
                    state_d = regmap_pkg::H_IDLE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            default: state_d = regmap_pkg::H_IDLE;
        endcase
        if (CMD_RD) begin
            case (CMD_ADDR)
                regmap_pkg::H_CTRL_ADDR: cmd_rdata_d = ctrl_q;
                regmap_pkg::H_TADDR_ADDR: cmd_rdata_d = taddr_q;
                regmap_pkg::H_TDATA_ADDR: cmd_rdata_d = tdata_q;
                regmap_pkg::H_STATUS_ADDR: begin
                    cmd_rdata_d[regmap_pkg::ST_BUSY_BIT] =
                        (state_q != regmap_pkg::H_IDLE);
                    cmd_rdata_d[regmap_pkg::ST_ACQ_BIT] = acq_err_q;
                    cmd_rdata_d[regmap_pkg::ST_LIMIT_BIT] = lim_err_q;
                end
                regmap_pkg::H_RDATA_ADDR: cmd_rdata_d = rdata_q;
                regmap_pkg::H_COUNT_ADDR: cmd_rdata_d = count_q;
                default: cmd_rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            state_q <= regmap_pkg::H_IDLE;
            ctrl_q <= 8'h00;
            taddr_q <= 8'h00;
            tdata_q <= 8'h00;
            rdata_q <= 8'h00;
            count_q <= 8'h00;
            acq_err_q <= 1'b0;
            lim_err_q <= 1'b0;
            req_q <= 1'b0;
            we_q <= 1'b0;
            cnt_q <= '0;
            cmd_rdata_q <= 8'h00;
        end else begin
            state_q <= state_d;
            ctrl_q <= ctrl_d;
            taddr_q <= taddr_d;
            tdata_q <= tdata_d;
            rdata_q <= rdata_d;
            count_q <= count_d;
            acq_err_q <= acq_err_d;
            lim_err_q <= lim_err_d;
            req_q <= req_d;
            we_q <= we_d;
            cnt_q <= cnt_d;
            cmd_rdata_q <= cmd_rdata_d;
        end
    end

    assign LINK.req = req_q;
    assign LINK.we = we_q;
    assign LINK.addr = taddr_q;
    assign LINK.wdata = tdata_q;
    assign CMD_RDATA = cmd_rdata_q;
endmodule

// >>> verilog/regmap_link_if.sv
interface regmap_link_if;
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    logic stretch;
    modport dev (input req, input we, input addr, input wdata,
                 output done, output rdata, output stretch);
    modport host (output req, output we, output addr, output wdata,
                  input done, input rdata, input stretch);
endinterface

// >>> verilog/regmap_pkg.sv
// Overview of operation
// - 256 byte-wide locations, 0x00 to 0xFF
// - upper half backed by nonvolatile store
// - every location reachable over the link
// - multi-byte registers: high byte, lower address
// - volatile page low, nonvolatile page high
// - control page returns to defaults on reset
// - 128-byte store maps one-to-one to upper page
// - pump on before store write, off after
// - master allows 20 ms per stored byte
// - stretch enabled: clock held while store busy
// - no stretch support: clear enable, wait 20 ms
// - no store writes during frame acquisition
// - at most 100 store writes per life; host write count clears on reset
// - read-only family and revision at 0x00, 0x01
// - indirect store access via 0x11 and 0x12
// - mask at 0x13 limits indirect write bits
// - four marker label registers at 0x1C-0x1F
// - strap pins captured into 0x20/0x21, read-only
// - modulation vectors at 0x22-0x2D and 0x3A-0x3C
package regmap_pkg;
    localparam logic [7:0] FAMILY_ADDR = 8'h00;
    localparam logic [7:0] REVISION_ADDR = 8'h01;
    localparam logic [7:0] IND_ADDR_ADDR = 8'h11;
    localparam logic [7:0] IND_VALUE_ADDR = 8'h12;
    localparam logic [7:0] IND_MASK_ADDR = 8'h13;
    localparam logic [7:0] MARK_FB_ADDR = 8'h1c;
    localparam logic [7:0] MARK_FF_ADDR = 8'h1d;
    localparam logic [7:0] MARK_LB_ADDR = 8'h1e;
    localparam logic [7:0] MARK_LF_ADDR = 8'h1f;
    localparam logic [7:0] PIN_HIGH_ADDR = 8'h20;
    localparam logic [7:0] PIN_LOW_ADDR = 8'h21;
    localparam logic [7:0] PH0_HIGH_ADDR = 8'h22;
    localparam logic [7:0] PH0_LOW_ADDR = 8'h24;
    localparam logic [7:0] PH1_HIGH_ADDR = 8'h25;
    localparam logic [7:0] PH1_LOW_ADDR = 8'h27;
    localparam logic [7:0] PH2_HIGH_ADDR = 8'h28;
    localparam logic [7:0] PH2_LOW_ADDR = 8'h2a;
    localparam logic [7:0] PH3_HIGH_ADDR = 8'h2b;
    localparam logic [7:0] PH3_LOW_ADDR = 8'h2d;
    localparam logic [7:0] GRAY_HIGH_ADDR = 8'h3a;
    localparam logic [7:0] GRAY_LOW_ADDR = 8'h3c;
    localparam logic [7:0] TEMP_HIGH_ADDR = 8'h60;
    localparam logic [7:0] TEMP_LOW_ADDR = 8'h61;
    localparam logic [7:0] LINK_CTRL_ADDR = 8'h7e;
    localparam int STRETCH_BIT = 0;
    localparam logic [7:0] LINK_CTRL_RESET = 8'h01;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam int VECTOR_BYTES = 10;
    localparam int NVM_WRITE_MS = 20;
    localparam int CLOCK_KHZ = 50_000;
    localparam int NVM_WRITE_CYCLES = NVM_WRITE_MS * CLOCK_KHZ;
    localparam int NVM_WRITE_LIMIT = 100;
    // host command registers
    localparam logic [3:0] H_CTRL_ADDR = 4'h0;
    localparam logic [3:0] H_TADDR_ADDR = 4'h1;
    localparam logic [3:0] H_TDATA_ADDR = 4'h2;
    localparam logic [3:0] H_GO_ADDR = 4'h3;
    localparam logic [3:0] H_STATUS_ADDR = 4'h4;
    localparam logic [3:0] H_RDATA_ADDR = 4'h5;
    localparam logic [3:0] H_COUNT_ADDR = 4'h6;
    localparam int GO_WRITE_BIT = 0;
    localparam int GO_READ_BIT = 1;
    localparam int TIMER_MODE_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ACQ_BIT = 1;
    localparam int ST_LIMIT_BIT = 2;
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_WAIT_DONE = 2'b01,
        H_WAIT_STRETCH = 2'b11,
        H_WAIT_TIMER = 2'b10
    } host_state_t;
endpackage
